//--- rtl/syscfg_cfg.svh
`ifndef SYSCFG_CFG_SVH
`define SYSCFG_CFG_SVH

`define SYSCFG_ADDR          32'h0000ff0c
`define SYSCFG_RESET         16'h0000
`define SYSCFG_WMASK         16'h7b3f
`define SYSCFG_CYCLE_TIME_CONTROL_LSB      0
`define SYSCFG_READ_WRITE_DELAY_CONTROL_BIT      4
`define SYSCFG_TRISTATE_TIME_CONTROL_BIT      5
`define SYSCFG_BUS_TYPE_FIELD_LSB      6
`define SYSCFG_BUS_TYPE_FIELD_MSB      7
`define SYSCFG_CLOCK_OUTPUT_ENABLE_BIT     8
`define SYSCFG_HIGH_BYTE_ENABLE_DISABLE_BIT    9
`define SYSCFG_INTERNAL_ROM_ENABLE_BIT     10
`define SYSCFG_SEGMENTATION_DISABLE_BIT    11
`define SYSCFG_READY_INPUT_ENABLE_BIT     12
`define SYSCFG_STACK_SIZE_SELECT_LSB     13
`define SYSCFG_ROM_LOW_FIRST 18'h00000
`define SYSCFG_ROM_LOW_LAST  18'h01fff
`define SYSCFG_SYNC_STAGES   3
`define SYSCFG_STRAP_SETTLE  3'h4

`endif

//--- rtl/syscfg_pkg.sv
package syscfg_pkg;

  typedef enum logic [1:0] {
    bus_none,
    bus_mux_8,
    bus_mux_16,
    bus_demux_16
  } bus_type_t;

  typedef struct packed {
    logic       reserved_15;
    logic [1:0] stack_size_select;
    logic       ready_input_enable;
    logic       segmentation_disable;
    logic       internal_rom_enable;
    logic       high_byte_enable_disable;
    logic       clock_output_enable;
    bus_type_t  bus_type_field;
    logic       tristate_time_control;
    logic       read_write_delay_control;
    logic [3:0] cycle_time_control;
  } system_configuration_t;

  typedef enum logic [1:0] {
    init_settle,
    init_load,
    running
  } init_state_t;

endpackage

//--- rtl/strap_sync.sv
`timescale 1ns/1ps
`include "syscfg_cfg.svh"

module strap_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] stage_reg [`SYSCFG_SYNC_STAGES];
  logic [WIDTH-1:0] out_reg;

  // Output moves only when the last two stages agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < `SYSCFG_SYNC_STAGES; i++) begin
        stage_reg[i] <= '0;
      end
      out_reg <= '0;
    end else begin
      stage_reg[0] <= pin_in;
      for (int i = 1; i < `SYSCFG_SYNC_STAGES; i++) begin
        stage_reg[i] <= stage_reg[i-1];
      end
      if (stage_reg[1] == stage_reg[2]) begin
        out_reg <= stage_reg[2];
      end
    end
  end

  assign pin_out = out_reg;

endmodule

//--- rtl/system_config_bus_select.sv
// Summary of operation
// - Bus type field loads from the two strap pins at reset.
// - Bus type field becomes read-only when reset chose an external bus.
// - External bus at reset disables internal ROM; ROM enable reads 0.
// - ROM enable 0 sends accesses 00000h..01FFFh to the external bus.
// - No external bus at reset enables internal ROM; ROM enable reads 1.
// - Single chip mode leaves the bus type field writable.
// - ROM enable 1 serves accesses 00000h..01FFFh from internal memory.
// - Multiplexed bus type adds one state time to tri-state time.
// - Register sits at FF0Ch; reset value follows straps.
// - Bus type codes: none, mux 8-bit, mux 16-bit, non-mux 16-bit.
// - Reserved bits cannot change and read as 0.
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`include "syscfg_cfg.svh"

module system_config_bus_select (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        bus_strap_pin_low,
  input  wire logic        bus_strap_pin_high,
  input  wire logic [17:0] mem_addr,
  input  wire logic        mem_req,
  output logic             mem_internal_rom,
  output logic             mem_external,
  output logic [1:0]       tristate_extra_states,
  output syscfg_pkg::system_configuration_t config_out
);

  syscfg_pkg::system_configuration_t cfg_reg;
  syscfg_pkg::system_configuration_t cfg_next;
  syscfg_pkg::init_state_t           state_reg;
  syscfg_pkg::init_state_t           state_next;
  logic [2:0]  settle_reg;
  logic        bus_type_field_locked_reg;
  logic        wr_pend_reg;
  logic [31:0] hrdata_reg;
  logic [1:0]  straps;

  strap_sync #(
    .WIDTH (2)
  ) u_strap_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .pin_in  ({bus_strap_pin_high, bus_strap_pin_low}),
    .pin_out (straps)
  );

  // Bus stalls until the straps have been captured
  wire        ready_w    = (state_reg == syscfg_pkg::running);
  wire        addr_phase = hsel && htrans[1] && hready && ready_w;
  wire        hit        = (haddr == `SYSCFG_ADDR);
  wire        wr_take    = addr_phase && hit && hwrite;
  wire        rd_take    = addr_phase && hit && !hwrite;
  wire        bus_type_field_strap_ext = (straps != 2'h0);
  wire [15:0] wmask      = `SYSCFG_WMASK
                         | (bus_type_field_locked_reg ? 16'h0000 : 16'h00c0);
  wire [15:0] cur_w      = cfg_reg;
  wire [15:0] wr_w       = (cur_w & ~wmask) | (hwdata[15:0] & wmask);
  wire        low_range  = (mem_addr >= `SYSCFG_ROM_LOW_FIRST)
                         && (mem_addr <= `SYSCFG_ROM_LOW_LAST);
  wire        rom_on     = cfg_reg.internal_rom_enable;
  wire        is_mux     = (cfg_reg.bus_type_field == syscfg_pkg::bus_mux_8)
                         || (cfg_reg.bus_type_field == syscfg_pkg::bus_mux_16);

  always_comb begin
    cfg_next   = cfg_reg;
    state_next = state_reg;
    case (state_reg)
      syscfg_pkg::init_settle: begin
        if (settle_reg == `SYSCFG_STRAP_SETTLE) begin
          state_next = syscfg_pkg::init_load;
        end
      end
      syscfg_pkg::init_load: begin
        cfg_next.bus_type_field      = syscfg_pkg::bus_type_t'(straps);
        cfg_next.internal_rom_enable = !bus_type_field_strap_ext;
        state_next                   = syscfg_pkg::running;
      end
      default: begin
        if (wr_pend_reg) begin
          cfg_next = syscfg_pkg::system_configuration_t'(wr_w);
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg   <= syscfg_pkg::system_configuration_t'(`SYSCFG_RESET);
      state_reg <= syscfg_pkg::init_settle;
    end else begin
      cfg_reg   <= cfg_next;
      state_reg <= state_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      settle_reg      <= 3'h0;
      bus_type_field_locked_reg <= 1'b0;
    end else begin
      if (state_reg == syscfg_pkg::init_settle) begin
        settle_reg <= settle_reg + 3'h1;
      end
      if (state_reg == syscfg_pkg::init_load) begin
        bus_type_field_locked_reg <= bus_type_field_strap_ext;
      end
    end
  end

  // Read data is formed in the address phase so hrdata comes from a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      hrdata_reg  <= 32'h00000000;
    end else begin
      wr_pend_reg <= wr_take;
      hrdata_reg  <= rd_take ? {16'h0000, cur_w & 16'h7fff} : 32'h00000000;
    end
  end

  assign hrdata    = hrdata_reg;
  assign hreadyout = ready_w;
  assign hresp     = 1'b0;

  assign mem_internal_rom = mem_req && low_range && rom_on;
  assign mem_external     = mem_req && !(low_range && rom_on);

  // Tri-state control 0 adds one state, multiplexed bus adds another
  assign tristate_extra_states = {1'b0, !cfg_reg.tristate_time_control}
                               + {1'b0, is_mux};
  assign config_out = cfg_reg;

endmodule

//--- verification/syscfg_properties.sv
`timescale 1ns/1ps
module syscfg_chk (
  input wire logic                              hclk,
  input wire logic                              hresetn,
  input wire logic                              hsel,
  input wire logic [31:0]                       haddr,
  input wire logic [1:0]                        htrans,
  input wire logic                              hwrite,
  input wire logic                              hreadyout,
  input wire logic                              hresp,
  input wire logic [31:0]                       hrdata,
  input wire logic                              bus_strap_pin_low,
  input wire logic                              bus_strap_pin_high,
  input wire logic [17:0]                       mem_addr,
  input wire logic                              mem_req,
  input wire logic                              mem_internal_rom,
  input wire logic                              mem_external,
  input wire logic [1:0]                        tristate_extra_states,
  input wire syscfg_pkg::system_configuration_t config_out
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire logic       rom = config_out.internal_rom_enable;
  wire logic [1:0] bt  = config_out.bus_type_field;
  wire logic [1:0] st  = {bus_strap_pin_high, bus_strap_pin_low};
  sequence rd_addr;
    hsel && htrans[1] && !hwrite && hreadyout && haddr == 32'h0000ff0c;
  endsequence
  chk_rom_route: assert property (mem_req && mem_addr <= 18'h01fff && rom
    |-> mem_internal_rom && !mem_external) else $error("rom route");
  chk_ext_route: assert property (mem_req && !rom |-> mem_external && !mem_internal_rom)
    else $error("ext route");
  chk_strap_load: assert property ($rose(hreadyout) |-> bt == st) else $error("strap");
  chk_rom_reset: assert property ($rose(hreadyout) |-> rom == (st == 2'h0))
    else $error("rom reset");
  chk_bus_locked: assert property (hreadyout && !rom |=> $stable(bt)) else $error("lock");
  chk_tristate_add: assert property (tristate_extra_states ==
    2'(!config_out.tristate_time_control) + 2'(bt == 2'h1 || bt == 2'h2)) else $error("tri");
  chk_reserved_zero: assert property (hrdata[31:15] == 17'h0 && !config_out.reserved_15)
    else $error("reserved");
  // Old value: a write in its data phase commits only at this edge
  chk_read_data: assert property (rd_addr |=> hrdata == {16'h0, $past(config_out)})
    else $error("read data");
  chk_okay_resp: assert property (!hresp) else $error("resp not okay");
endmodule
bind system_config_bus_select syscfg_chk i_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hreadyout, .hresp, .hrdata, .bus_strap_pin_low, .bus_strap_pin_high, .mem_addr,
  .mem_req, .mem_internal_rom, .mem_external, .tristate_extra_states, .config_out);

//--- verification/tb.sv
`timescale 1ns/1ps
module tb;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, mem_req = 0, rd_q = 0;
  logic        bus_strap_pin_low = 0, bus_strap_pin_high = 0;
  logic [1:0]  htrans = 0, tristate_extra_states;
  logic [2:0]  hsize = 3'h2;
  logic [17:0] mem_addr = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, exp;
  logic        hreadyout, hresp, mem_internal_rom, mem_external;
  wire logic   hready = hreadyout;
  logic [31:0] q[$];
  int          num_errors = 0, checks = 0;
  syscfg_pkg::system_configuration_t config_out;
  always #25 hclk = ~hclk;
  system_config_bus_select i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hrdata, .hreadyout, .hresp, .bus_strap_pin_low, .bus_strap_pin_high,
    .mem_addr, .mem_req, .mem_internal_rom, .mem_external, .tristate_extra_states, .config_out);
  always @(posedge hclk) begin
    if (rd_q && hready) begin
      exp = q.pop_front();
      checks++;
      if (hrdata !== exp) begin
        num_errors++;
        $display("MISMATCH t=%0t got %h exp %h", $time, hrdata, exp);
      end
    end
    if (hready) rd_q <= hsel && htrans[1] && !hwrite;
  end
  task finish_test;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Sampled at negedge so the flop-driven ready has settled
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(negedge hclk);
      n++;
    end while (!hreadyout && n < 50);
    if (!hreadyout) begin
      num_errors++;
      finish_test();
    end
    @(posedge hclk);
  endtask
  task xfer(input logic w, input logic [31:0] a, d);
    hsel <= 1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask
  task rd(input logic [31:0] a, e);
    q.push_back(e);
    xfer(0, a, 32'h0);
  endtask
  initial begin
    logic [15:0] e, m;
    logic [31:0] d;
    void'($urandom(45));
    for (int s = 0; s < 4; s++) begin
      {bus_strap_pin_high, bus_strap_pin_low} <= 2'(s);
      hresetn <= 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1;
      wait_rdy();
      e = s == 0 ? 16'h0400 : {8'h0, 2'(s), 6'h0};
      rd(32'h0000ff0c, {16'h0, e});
      d = $urandom;
      m = s == 0 ? 16'h7bff : 16'h7b3f;
      e = (d[15:0] & m) | (e & ~m);
      xfer(1, 32'h0000ff0c, d);
      @(posedge hclk);
      rd(32'h0000ff0c, {16'h0, e});
      rd(32'h0000ff10, 32'h0);
      repeat (8) begin
        @(posedge hclk);
        mem_req <= 1;
        mem_addr <= 18'($urandom % 16384);
      end
    end
    finish_test();
  end
endmodule
